// [hdl/codec_slot_buffer_control.sv]
`timescale 1ns/1ps
module codec_slot_buffer_control (
  input  wire logic        clk_i,              // System clock, 25 MHz.
  input  wire logic        rst_b_i,            // Asynchronous reset, active low.
  input  wire logic        serial_bit_clock_i, // Bit clock from the codec.
  input  wire logic        frame_sync_i,       // Frame sync pin level.
  output logic             frame_sync_o,       // Frame sync driven as master.
  output logic             frame_sync_oe_o,    // High while frame sync is driven.
  input  wire logic        serial_in_i,        // Serial data from the codec.
  output logic             serial_out_o,       // Serial data to the codec.
  output logic             serial_out_oe_o,    // High while serial output is driven.
  input  wire logic [4:0]  reg_addr_i,         // Register byte address.
  input  wire logic [15:0] reg_wdata_i,        // Register write data.
  input  wire logic        reg_wr_i,           // Write strobe.
  input  wire logic        reg_rd_i,           // Read strobe.
  output logic [15:0]      reg_rdata_o,        // Read data in the cycle after the strobe.
  output logic             transfer_irq_o      // One-cycle pulse per shadow transfer.
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Registers and fields.

  logic [15:0]     ctrl_a;
  logic [15:0]     ctrl_b;
  logic [15:0]     transmit_slot_enables;
  logic [15:0]     receive_slot_enables;
  logic [15:0]     tx_holding_word [4];
  logic [15:0]     rx_holding_word [4];
  logic [15:0]     tx_shadow [4];
  logic [15:0]     rx_shadow [4];
  logic            tx_written [4];
  logic            shadow_unf [4];
  logic            unf_loc [4];
  logic            unread_loc [4];
  logic            ovf_loc [4];
  logic [3:0]      unf_v;
  logic [3:0]      unread_v;
  logic [3:0]      ovf_v;
  logic            tx_empty_flag;
  logic [15:0]     status_word;

  wire             module_on        = ctrl_a[csb_pkg::BIT_MODULE_ON];
  wire             loopback_on      = ctrl_a[csb_pkg::BIT_LOOPBACK];
  wire             sample_edge_sel  = ctrl_a[csb_pkg::BIT_SAMPLE_EDG];
  wire             frame_dir_slave  = ctrl_a[csb_pkg::BIT_FRAME_SLV];
  wire             underflow_repeat = ctrl_a[csb_pkg::BIT_UNF_REPEAT];
  wire             idle_slot_hiz    = ctrl_a[csb_pkg::BIT_IDLE_HIZ];
  wire             early_justify    = ctrl_a[csb_pkg::BIT_EARLY_JUST];
  wire [1:0]       buffer_length    = ctrl_b[csb_pkg::BUF_LEN_LSB +: 2];
  wire [3:0]       frame_len        = ctrl_b[csb_pkg::FLEN_LSB +: 4];
  wire [3:0]       word_size        = ctrl_b[csb_pkg::WORD_SIZE_LSB +: 4];

  // Software writes to the control and slot enable words.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_a                <= csb_pkg::CTRL_RST;
      ctrl_b                <= csb_pkg::CTRL_RST;
      transmit_slot_enables <= csb_pkg::SLOTS_RST;
      receive_slot_enables  <= csb_pkg::SLOTS_RST;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        csb_pkg::OFS_CTRL_A:   ctrl_a <= reg_wdata_i;
        csb_pkg::OFS_CTRL_B:   ctrl_b <= reg_wdata_i;
        csb_pkg::OFS_TX_SLOTS: transmit_slot_enables <= reg_wdata_i;
        csb_pkg::OFS_RX_SLOTS: receive_slot_enables <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bit clock edges.

  pin_if pins ();

  pin_sync u_pin_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .sclk_i  (serial_bit_clock_i),
    .fs_i    (frame_sync_i),
    .sdi_i   (serial_in_i),
    .pins    (pins)
  );

  // Data changes on the edge opposite the sampling edge. Clearing the enable stops both.
  wire drive_tick  = module_on & (sample_edge_sel ? pins.sclk_fall : pins.sclk_rise);
  wire sample_tick = module_on & (sample_edge_sel ? pins.sclk_rise : pins.sclk_fall);

  // In loopback the pin is ignored and the registered output is read back.
  wire rx_bit      = loopback_on ? serial_out_o : pins.sdi_lvl;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: bit counter, slot counter, start of frame.

  csb_pkg::frame_e state;
  logic [3:0]      bit_cnt;
  logic [3:0]      slot_cnt;
  logic [1:0]      ptr;

  wire        slot_last  = bit_cnt == word_size;
  wire        frame_last = slot_cnt == frame_len;
  wire        slot_end   = drive_tick & (state == csb_pkg::FR_RUN) & slot_last;

  // A slave listens for sync only between frames; a frame in flight runs to its end.
  wire        fs_hit      = frame_dir_slave & pins.fs_lvl & sample_tick &
                            (state != csb_pkg::FR_RUN);
  wire        start_early = fs_hit & early_justify;

  // The slot counter wraps at the frame length, so higher enables are never looked at.
  wire        new_slot  = drive_tick & ((state == csb_pkg::FR_ARMED) |
                          (~frame_dir_slave & (state == csb_pkg::FR_IDLE)) |
                          (slot_end & (~frame_last | ~frame_dir_slave)));
  wire [3:0]  next_slot = (slot_end & ~frame_last) ? 4'(slot_cnt + 4'h1) : 4'h0;
  wire [3:0]  next_bit  = new_slot ? 4'h0 : 4'(bit_cnt + 4'h1);
  wire [3:0]  next_pos  = new_slot ? next_slot : slot_cnt;
  wire        fs_lead   = (next_bit == word_size) & (next_pos == frame_len);

  wire        eff_run   = (state == csb_pkg::FR_RUN) | start_early;
  wire [3:0]  eff_bit   = start_early ? 4'h0 : bit_cnt;
  wire [3:0]  eff_slot  = start_early ? 4'h0 : slot_cnt;
  wire        rx_on     = receive_slot_enables[eff_slot];
  wire        tx_cur_on = transmit_slot_enables[slot_cnt];

  // State and counters; a slave frame ends after its last slot and waits for sync.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state    <= csb_pkg::FR_IDLE;
      bit_cnt  <= 4'h0;
      slot_cnt <= 4'h0;
    end else if (!module_on) begin
      state    <= csb_pkg::FR_IDLE;
      bit_cnt  <= 4'h0;
      slot_cnt <= 4'h0;
    end else if (start_early) begin
      state    <= csb_pkg::FR_RUN;
      bit_cnt  <= 4'h0;
      slot_cnt <= 4'h0;
    end else if (fs_hit) begin
      state    <= csb_pkg::FR_ARMED;
    end else if (drive_tick) begin
      if (new_slot) begin
        state    <= csb_pkg::FR_RUN;
        bit_cnt  <= 4'h0;
        slot_cnt <= next_slot;
      end else if (slot_end) begin
        state    <= csb_pkg::FR_IDLE;
      end else if (state == csb_pkg::FR_RUN) begin
        bit_cnt  <= next_bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Shared buffer pointer and shadow transfer.

  // One step per slot enabled in either direction; both directions share the pointer.
  wire        adv     = slot_end & (tx_cur_on | receive_slot_enables[slot_cnt]);
  wire        xfer    = adv & (ptr == buffer_length);
  wire [1:0]  ptr_new = xfer ? 2'h0 : 2'(ptr + {1'b0, adv});

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr <= 2'h0;
    end else if (!module_on) begin
      ptr <= 2'h0;
    end else begin
      ptr <= ptr_new;
    end
  end

  // The interrupt pulse follows the transfer by one cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      transfer_irq_o <= 1'b0;
    end else begin
      transfer_irq_o <= xfer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Transmit path.

  logic [15:0] tx_sr;
  logic        tx_active;

  // On a transfer the new slot's word comes straight from the holding word, since the
  // shadow only takes it at this same edge.
  wire         load_unf  = xfer ? ~tx_written[0] : shadow_unf[ptr_new];
  wire [15:0]  load_word = xfer ? tx_holding_word[0] : tx_shadow[ptr_new];

  // Shift out from the top bit, so only the top word_size+1 bits ever leave.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_sr     <= 16'h0000;
      tx_active <= 1'b0;
    end else if (!module_on) begin
      tx_sr     <= 16'h0000;
      tx_active <= 1'b0;
    end else if (new_slot | start_early) begin
      tx_active <= transmit_slot_enables[next_slot];
      tx_sr     <= (load_unf & ~underflow_repeat) ? 16'h0000 : load_word;
    end else if (slot_end) begin
      tx_active <= 1'b0;
    end else if (drive_tick & (state == csb_pkg::FR_RUN)) begin
      tx_sr     <= {tx_sr[14:0], 1'b0};
    end
  end

  // Pin drivers; idle slots drive low or float as chosen.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      serial_out_o    <= tx_active & tx_sr[15];
      serial_out_oe_o <= module_on & (tx_active | ~idle_slot_hiz);
    end
  end

  // As master the sync leads the frame by one bit, or marks its first bit when early.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frame_sync_o    <= 1'b0;
      frame_sync_oe_o <= 1'b0;
    end else begin
      frame_sync_oe_o <= module_on & ~frame_dir_slave;
      if (!module_on | frame_dir_slave) begin
        frame_sync_o <= 1'b0;
      end else if (drive_tick) begin
        frame_sync_o <= early_justify ? (new_slot & (next_slot == 4'h0)) : fs_lead;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Receive path.

  logic [15:0] rx_sr;

  wire         rx_commit = sample_tick & eff_run & (eff_bit == word_size) & rx_on;
  wire [15:0]  rx_full_w = {rx_sr[14:0], rx_bit};
  wire [15:0]  rx_word   = rx_full_w << (4'hf - word_size);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sr <= 16'h0000;
    end else if (sample_tick & eff_run) begin
      rx_sr <= rx_full_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Per-location buffers and status tracking.

  wire any_tx_wr = reg_wr_i & ~reg_addr_i[0] &
                   (reg_addr_i[4:3] == csb_pkg::OFS_TX_BASE[4:3]);

  for (genvar i = 0; i < 4; i++) begin : g_loc
    localparam logic [1:0] IDX = 2'(i);
    wire in_use = IDX <= buffer_length;
    wire take   = xfer & in_use;
    wire wr_me  = reg_wr_i & (reg_addr_i == 5'(csb_pkg::OFS_TX_BASE + 5'(2 * i)));
    wire rd_me  = reg_rd_i & (reg_addr_i == 5'(csb_pkg::OFS_RX_BASE + 5'(2 * i)));

    // Transmit side; a write in the transfer cycle still counts as a refill afterwards.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        tx_holding_word[i] <= csb_pkg::BUF_RST;
        tx_shadow[i]       <= csb_pkg::BUF_RST;
        shadow_unf[i]      <= 1'b0;
        tx_written[i]      <= 1'b0;
        unf_loc[i]         <= 1'b0;
      end else begin
        if (wr_me) begin
          tx_holding_word[i] <= reg_wdata_i;
        end
        if (take) begin
          tx_shadow[i]  <= tx_holding_word[i];
          shadow_unf[i] <= ~tx_written[i];
        end
        if (wr_me) begin
          tx_written[i] <= 1'b1;
        end else if (take) begin
          tx_written[i] <= 1'b0;
        end
        if (take & ~tx_written[i]) begin
          unf_loc[i] <= 1'b1;
        end else if (wr_me) begin
          unf_loc[i] <= 1'b0;
        end
      end
    end

    // Receive side; new data overwrites an unread word and marks the overflow.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        rx_shadow[i]       <= csb_pkg::BUF_RST;
        rx_holding_word[i] <= csb_pkg::BUF_RST;
        unread_loc[i]      <= 1'b0;
        ovf_loc[i]         <= 1'b0;
      end else begin
        if (rx_commit & (ptr == IDX)) begin
          rx_shadow[i] <= rx_word;
        end
        if (take) begin
          rx_holding_word[i] <= rx_shadow[i];
          unread_loc[i]      <= 1'b1;
        end else if (rd_me) begin
          unread_loc[i]      <= 1'b0;
        end
        if (take & unread_loc[i]) begin
          ovf_loc[i] <= 1'b1;
        end else if (rd_me) begin
          ovf_loc[i] <= 1'b0;
        end
      end
    end

    // Locations beyond the buffer length are masked out of the underflow, full and overflow flags.
    assign unf_v[i]    = unf_loc[i] & in_use;
    assign unread_v[i] = unread_loc[i] & in_use;
    assign ovf_v[i]    = ovf_loc[i] & in_use;
  end

  // Transmit-empty; a transfer beats a write in the same cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_empty_flag <= 1'b0;
    end else if (xfer) begin
      tx_empty_flag <= 1'b1;
    end else if (any_tx_wr) begin
      tx_empty_flag <= 1'b0;
    end
  end

  // Status word as software sees it.
  always_comb begin
    status_word                             = 16'h0000;
    status_word[csb_pkg::SLOT_LSB +: 4]     = slot_cnt;
    status_word[csb_pkg::BIT_RX_OVF]        = |ovf_v;
    status_word[csb_pkg::BIT_RX_FULL]       = |unread_v;
    status_word[csb_pkg::BIT_TX_UNF]        = |unf_v;
    status_word[csb_pkg::BIT_TX_EMPTY]      = tx_empty_flag;
  end

  // Read data stand for exactly one cycle; unmapped addresses read zero.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_addr_i[4] & ~reg_addr_i[0]) begin
      reg_rdata_o <= reg_addr_i[3] ? tx_holding_word[reg_addr_i[2:1]]
                                   : rx_holding_word[reg_addr_i[2:1]];
    end else begin
      case (reg_addr_i)
        csb_pkg::OFS_CTRL_A:   reg_rdata_o <= ctrl_a;
        csb_pkg::OFS_CTRL_B:   reg_rdata_o <= ctrl_b;
        csb_pkg::OFS_STATUS:   reg_rdata_o <= status_word;
        csb_pkg::OFS_TX_SLOTS: reg_rdata_o <= transmit_slot_enables;
        csb_pkg::OFS_RX_SLOTS: reg_rdata_o <= receive_slot_enables;
        default:               reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  wire idle_drive = module_on & ~idle_slot_hiz;

  sequence s_frame_top;
    (state == csb_pkg::FR_RUN) && (bit_cnt == 4'h0) && (slot_cnt == 4'h0);
  endsequence

  sequence s_pulse_once;
    transfer_irq_o ##1 !transfer_irq_o;
  endsequence

  AST_SAMPLE_EDGE: assert property ((rx_sr != $past(rx_sr)) |-> $past(sample_tick))
    else $error("Receive shift outside the sampling edge.");
  AST_LATE_START: assert property (fs_hit && !early_justify |=>
                                   state == csb_pkg::FR_ARMED ##1
                                   (state == csb_pkg::FR_ARMED) || (state == csb_pkg::FR_RUN))
    else $error("Default justification did not wait one bit.");
  AST_EARLY_START: assert property (start_early |=> s_frame_top)
    else $error("Early justification did not start the frame at once.");
  AST_TX_LOAD: assert property (new_slot && transmit_slot_enables[next_slot] |=> tx_active)
    else $error("Enabled slot did not load the transmit word.");
  AST_IDLE_PIN: assert property (!tx_active |=> !serial_out_o &&
                                 (serial_out_oe_o == $past(idle_drive)))
    else $error("Idle slot drive wrong.");
  AST_XFER_RESET: assert property (xfer |=> (ptr == 2'h0) && tx_empty_flag)
    else $error("Shadow transfer did not reset the pointer.");
  AST_IRQ: assert property (xfer |=> s_pulse_once)
    else $error("Transfer interrupt not a single pulse.");
  AST_EMPTY_CLR: assert property (any_tx_wr && !xfer |=> !tx_empty_flag)
    else $error("Transmit write did not clear empty.");
  AST_OVERFLOW: assert property (xfer && (|unread_v) |=> |ovf_v)
    else $error("Overwrite of unread data not flagged.");
  AST_HOLD_IDLE: assert property ((state == csb_pkg::FR_IDLE) && frame_dir_slave &&
                                  module_on |=> $stable(ptr))
    else $error("Pointer moved between frames.");
  AST_DISABLE: assert property (!module_on |=> (state == csb_pkg::FR_IDLE) &&
                                (ptr == 2'h0) && (bit_cnt == 4'h0))
    else $error("Disable did not reset the counters.");
endmodule

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk_i,   // System clock.
  input  wire logic rst_b_i, // Asynchronous reset, active low.
  input  wire logic sclk_i,  // Bit clock pin.
  input  wire logic fs_i,    // Frame sync pin.
  input  wire logic sdi_i,   // Serial data pin.
  pin_if.src        pins     // Synchronised levels and bit clock edges.
);
  logic [2:0] meta;
  logic [2:0] stable;
  logic       sclk_q;

  // Two stages per pin; only the second stage is looked at further on.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= 3'h0;
      stable <= 3'h0;
    end else begin
      meta   <= {sclk_i, fs_i, sdi_i};
      stable <= meta;
    end
  end

  // One extra stage of the bit clock gives its edges.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= stable[2];
    end
  end

  // Edge pulses last one system clock cycle.
  assign pins.sclk_rise = stable[2] & ~sclk_q;
  assign pins.sclk_fall = ~stable[2] & sclk_q;
  assign pins.fs_lvl    = stable[1];
  assign pins.sdi_lvl   = stable[0];
endmodule

// [pkg/csb_pkg.sv]
package csb_pkg;
  // Register byte offsets on the plain register port.
  localparam logic [4:0]  OFS_CTRL_A   = 5'h00;
  localparam logic [4:0]  OFS_CTRL_B   = 5'h02;
  localparam logic [4:0]  OFS_STATUS   = 5'h06;
  localparam logic [4:0]  OFS_TX_SLOTS = 5'h08;
  localparam logic [4:0]  OFS_RX_SLOTS = 5'h0c;
  localparam logic [4:0]  OFS_RX_BASE  = 5'h10;
  localparam logic [4:0]  OFS_TX_BASE  = 5'h18;
  localparam int unsigned ADDR_W       = 5;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned WORDS        = 4;

  // Control word A bit positions.
  localparam int unsigned BIT_MODULE_ON  = 15;
  localparam int unsigned BIT_LOOPBACK   = 11;
  localparam int unsigned BIT_SAMPLE_EDG = 9;
  localparam int unsigned BIT_FRAME_SLV  = 8;
  localparam int unsigned BIT_UNF_REPEAT = 7;
  localparam int unsigned BIT_IDLE_HIZ   = 6;
  localparam int unsigned BIT_EARLY_JUST = 5;

  // Control word B field positions.
  localparam int unsigned BUF_LEN_LSB   = 10;
  localparam int unsigned FLEN_LSB      = 4;
  localparam int unsigned WORD_SIZE_LSB = 0;

  // Status word bit positions.
  localparam int unsigned SLOT_LSB     = 8;
  localparam int unsigned BIT_RX_OVF   = 3;
  localparam int unsigned BIT_RX_FULL  = 2;
  localparam int unsigned BIT_TX_UNF   = 1;
  localparam int unsigned BIT_TX_EMPTY = 0;

  // Reset values.
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] SLOTS_RST = 16'h0000;
  localparam logic [15:0] BUF_RST   = 16'h0000;

  // Frame sequencer states.
  typedef enum logic [2:0] {
    FR_IDLE  = 3'b001,
    FR_ARMED = 3'b010,
    FR_RUN   = 3'b100
  } frame_e;
endpackage

// [pkg/pin_if.sv]
`timescale 1ns/1ps
interface pin_if;
  logic sclk_rise;
  logic sclk_fall;
  logic fs_lvl;
  logic sdi_lvl;
  modport src (output sclk_rise, output sclk_fall, output fs_lvl, output sdi_lvl);
  modport dst (input sclk_rise, input sclk_fall, input fs_lvl, input sdi_lvl);
endinterface

// [test/codec_model.sv]
`timescale 1ns/1ps
// Far-side codec; its bit clock stands still between frames.
module codec_model (
  output logic sclk_o = 1'b0, // Bit clock.
  output logic fs_o   = 1'b0, // Frame sync.
  output logic sdi_o  = 1'b0  // Data to the block, no pull.
);
  // Plain bits for master runs; data toggles so a missed loopback shows.
  task automatic run(input int n);
    #7;
    repeat (n) begin
      sclk_o = 1'b1;
      sdi_o  = ~sdi_o;
      #160 sclk_o = 1'b0;
      #160;
    end
  endtask
  // Slave frame: sync bit, 8 bits MSB first, 2 spare bits to close the slot.
  task automatic send(input logic [7:0] d, input logic s, input logic e);
    #7 sclk_o = s;
    #160;
    for (int i = -1; i < 10; i++) begin
      sclk_o = ~s;
      fs_o   = (i == (e ? 0 : -1));
      sdi_o  = (i >= 0 && i < 8) ? d[7-i] : ~sdi_o;
      #160 sclk_o = s;
      #160;
    end
    fs_o = 1'b0;
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clk_i   = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [4:0]  adr     = 5'h00;
  logic [15:0] wd      = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        rd_q    = 1'b0;
  logic [15:0] rdata, wa, wb, exp_q[$], msk_q[$];
  logic        sclk, fs, sdi, irq, fso, fs_oe, so_oe;
  logic        fs_q = 1'b0;
  int          n_fs = 0;
  logic [7:0]  d;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          n_irq     = 0;

  codec_model codec_model_i (.sclk_o(sclk), .fs_o(fs), .sdi_o(sdi));
  codec_slot_buffer_control codec_slot_buffer_control_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .serial_bit_clock_i(sclk),
    .frame_sync_i(fs), .frame_sync_o(fso), .frame_sync_oe_o(fs_oe),
    .serial_in_i(sdi), .serial_out_o(), .serial_out_oe_o(so_oe),
    .reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .transfer_irq_o(irq));

  // Free-running system clock.
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Read data stand only the cycle after the strobe, so compare then.
  always @(posedge clk_i) begin
    rd_q <= rd;
    if (rd_q) begin
      check("reg_rdata_o", rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    // Each master frame after the first shows one sync pulse; count its rising edges.
    fs_q <= fso;
    if (fso === 1'b1 && fs_q !== 1'b1) begin
      n_fs <= n_fs + 1;
    end
    if (irq === 1'b1) begin
      n_irq <= n_irq + 1;
    end
  end
  task automatic report_and_stop();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One access then an idle cycle; a read notes v under mask m.
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] v,
                     input logic [15:0] m);
    adr <= a;
    wd  <= v;
    wr  <= w;
    rd  <= !w;
    if (!w) begin
      exp_q.push_back(v & m);
      msk_q.push_back(m);
    end
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask
  // Bounded wait for the n-th transfer pulse.
  task automatic wait_irq(input int n);
    for (int i = 0; i < 4000 && n_irq < n; i++) @(posedge clk_i);
    if (n_irq < n) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(76));
    wa = 16'($urandom());
    wb = 16'($urandom());
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, csb_pkg::OFS_CTRL_A, 16'h0000, 16'hffff);
    bus(1'b0, 5'h04, 16'h0000, 16'hffff);
    bus(1'b1, csb_pkg::OFS_TX_SLOTS, 16'h0001, 16'h0);
    bus(1'b0, csb_pkg::OFS_TX_SLOTS, 16'h0001, 16'hffff);
    bus(1'b1, csb_pkg::OFS_RX_SLOTS, 16'h0003, 16'h0);
    bus(1'b1, csb_pkg::OFS_CTRL_B, 16'h041f, 16'h0);
    bus(1'b1, csb_pkg::OFS_TX_BASE, wa, 16'h0);
    bus(1'b1, csb_pkg::OFS_TX_BASE + 5'h02, wb, 16'h0);
    fork
      codec_model_i.run(140);
    join_none
    // Master with loopback; the first frame sends the empty shadows.
    bus(1'b1, csb_pkg::OFS_CTRL_A, 16'h8800, 16'h0);
    wait_irq(1);
    check("frame_sync_oe_o", {15'h0000, fs_oe}, 16'h0001);
    check("serial_out_oe_o", {15'h0000, so_oe}, 16'h0001);
    bus(1'b0, csb_pkg::OFS_STATUS, 16'h0005, 16'h000f);
    bus(1'b0, csb_pkg::OFS_RX_BASE, 16'h0000, 16'hffff);
    bus(1'b0, csb_pkg::OFS_RX_BASE + 5'h02, 16'h0000, 16'hffff);
    bus(1'b1, csb_pkg::OFS_TX_BASE + 5'h02, wb, 16'h0);
    wait_irq(2);
    bus(1'b0, csb_pkg::OFS_STATUS, 16'h0007, 16'h000f);
    bus(1'b0, csb_pkg::OFS_RX_BASE, wa, 16'hffff);
    bus(1'b0, csb_pkg::OFS_RX_BASE + 5'h02, 16'h0000, 16'hffff);
    bus(1'b1, csb_pkg::OFS_CTRL_A, 16'h8880, 16'h0);
    bus(1'b1, csb_pkg::OFS_TX_BASE + 5'h02, wb, 16'h0);
    wait_irq(3);
    bus(1'b1, csb_pkg::OFS_TX_BASE + 5'h02, wb, 16'h0);
    wait_irq(4);
    bus(1'b0, csb_pkg::OFS_STATUS, 16'h000f, 16'h000f);
    bus(1'b0, csb_pkg::OFS_RX_BASE, wa, 16'hffff);
    bus(1'b0, csb_pkg::OFS_RX_BASE + 5'h02, 16'h0000, 16'hffff);
    bus(1'b0, csb_pkg::OFS_STATUS, 16'h0000, 16'h000c);
    wait fork;
    check("frame_sync_o pulses", 16'(n_fs), 16'h0004);
    // Slave frames over every sample edge and justification choice; early ones float idle.
    bus(1'b1, csb_pkg::OFS_CTRL_A, 16'h0000, 16'h0);
    bus(1'b0, csb_pkg::OFS_STATUS, 16'h0000, 16'h0f00);
    bus(1'b1, csb_pkg::OFS_CTRL_B, 16'h0007, 16'h0);
    bus(1'b1, csb_pkg::OFS_RX_SLOTS, 16'hffff, 16'h0);
    for (int e = 0; e < 4; e++) begin
      d = 8'($urandom());
      bus(1'b1, csb_pkg::OFS_CTRL_A, {6'h20, e[0], 1'b1, 1'b0, e[1], e[1], 5'h00}, 16'h0);
      codec_model_i.send(d, e[0], e[1]);
      @(posedge clk_i);
      wait_irq(5 + e);
      check("serial_out_oe_o", {15'h0000, so_oe}, 16'(!e[1]));
      check("frame_sync_oe_o", {15'h0000, fs_oe}, 16'h0000);
      bus(1'b0, csb_pkg::OFS_RX_BASE, {d, 8'h00}, 16'hffff);
    end
    check("frame_sync_o pulses", 16'(n_fs), 16'h0004);
    report_and_stop();
  end
endmodule
